// [design/ext_bus_defs.svh]
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
// register indexes on the plain register port
`define CTRL_ADDR   4'h0
`define STAT_ADDR   4'h1
`define CTRL_RESET  8'h00
`define CTRL_MASK   8'hb3
`define RELEASE_BIT 7
`define STALL_HI    5
`define STALL_LO    4
`define WMODE_HI    1
`define WMODE_LO    0
// memory mode / address width codes
`define MODE_A20    2'h0
`define MODE_A16    2'h1
`define MODE_A12    2'h2
`define MODE_OFF    2'h3
`define MASK_A20    20'hfffff
`define MASK_A16    20'h0ffff
`define MASK_A12    20'h00fff
`define MASK_D8     20'h000ff
// control port bit positions
`define CTL_ALE     0
`define CTL_OE      1
`define CTL_WRL     2
`define CTL_WRH     3
`define CTL_BA0     4
`define CTL_CE      5
`define CTL_LB      6
`define CTL_UB      7
`define CTL_IDLE    8'hee
`define LINES       20
`endif

// [design/ext_bus_pkg.sv]
package ext_bus_pkg;
   // one-hot bus cycle states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ADDR  = 5'b00010,
      ST_DATA  = 5'b00100,
      ST_STALL = 5'b01000,
      ST_DONE  = 5'b10000
   } state_type;

   // one core access request
   typedef struct packed {
      logic        write;   // table write, else read
      logic        table_op; // table op, else fetch
      logic        hi_byte; // byte lane for byte modes
      logic [19:0] addr;
      logic [15:0] wdata;   // table latch contents
   } mem_req_type;

   // shared address/data and upper address pins
   typedef struct packed {
      logic [19:0] dout;
      logic [19:0] oe_n;
   } lines_type;

   // bus control port pins
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
   } ctl_pins_type;
endpackage

// [design/external_memory_bus_control.sv]
`timescale 1ns/10ps
`include "ext_bus_defs.svh"

// Summary of operation
// - bus supports 8 or 16 bit data and three address widths up to 20 bits.
// - 28 shared pins: 20 address/data lines plus an 8-bit control port.
// - lines 0-15 carry address then data, lines 8-15 address only in 8-bit width; lines 16-19 carry address only.
// - control bits 0-7: ALE, OE, WRITE_STROBE_LOW_BYTE, WRITE_STROBE_HIGH_BYTE, BA0, CE, LB, UB.
// - with the bus disabled by configuration the control register ignores writes.
// - release bit clear: bus owns its pins permanently over port I/O.
// - release bit set: pins are port I/O except during external accesses.
// - release bit resets to zero, so the bus owns its pins.
// - wait field 11,10,01,00 adds 0,1,2,3 cycles to table operations.
// - word write mode drives the latch word (bits 11:0 only with 12-bit addressing) and pulses WRITE_STROBE_HIGH_BYTE with both UB and LB.
// - byte select mode copies the byte to both halves, WRITE_STROBE_HIGH_BYTE plus UB or LB.
// - byte write mode copies the byte to both halves, WRITE_STROBE_HIGH_BYTE or WRITE_STROBE_LOW_BYTE.
// - write mode field has no effect with 8-bit data width.
// - unimplemented bits 6,3,2 read zero; implemented bits reset to zero.
// - control register shares its address with timer-2 period, chosen by select.
// - address and data width come only from configuration inputs.
// - data width configuration set selects 16-bit, cleared selects 8-bit.
// - mode field picks 20, 16, 12-bit addressing or bus disabled; 01 is 16-bit.
// - unused upper address lines stay port I/O regardless of release bit.
// - address and data are time-multiplexed on shared lines every cycle.
// - waits only with wait-enable set, inserted after the data cycle.
// - idle owned bus floats lines, CE OE WR UB LB high, ALE BA0 low.
// - ALE marks the address, then OE reads the word, masked to 8 bits in 8-bit width and to 12 with 12-bit addressing.
// - CE is active during each access outside sleep and held high during sleep while the bus owns the control port.
module external_memory_bus_control (
   input  wire logic                       core_clk,           // 25 MHz core clock
   input  wire logic                       nrst,               // async reset
   input  wire logic [3:0]                 reg_addr,           // register index
   input  wire logic [7:0]                 reg_wdata,          // write data
   input  wire logic                       reg_wr,             // write strobe
   input  wire logic                       reg_rd,             // read strobe
   output logic [7:0]                      reg_rdata,          // read data, next cycle
   input  wire logic                       shared_addr_select, // picks control over period
   output logic [7:0]                      timer2_period_reg,  // shared-address neighbour
   input  wire logic                       data_width_cfg,     // 1 = 16-bit data
   input  wire logic [1:0]                 memory_mode_width_cfg, // address width code
   input  wire logic                       wait_enable_cfg,    // table wait enable
   input  wire logic                       sleep_mode,         // device asleep
   input  wire logic                       req_valid,          // core access request
   input  ext_bus_pkg::mem_req_type        req,                // request contents
   output logic                            req_ready,          // request taken
   output logic                            resp_valid,         // access finished
   output logic [15:0]                     resp_data,          // read word
   input  wire logic [19:0]                line_in,            // pin levels
   input  ext_bus_pkg::lines_type          gpio_lines,         // port I/O drive
   output ext_bus_pkg::lines_type          lines,              // line pins
   input  ext_bus_pkg::ctl_pins_type       ctl_gpio,           // port I/O drive
   output ext_bus_pkg::ctl_pins_type       ctl_pins            // control pins
);

   // active address lines for a memory mode
   function automatic logic [19:0] line_mask(input logic [1:0] mode);
      case (mode)
         `MODE_A20: line_mask = `MASK_A20;
         `MODE_A16: line_mask = `MASK_A16;
         `MODE_A12: line_mask = `MASK_A12;
         default:   line_mask = 20'h00000;
      endcase
   endfunction

   ext_bus_pkg::state_type   state_reg;
   ext_bus_pkg::state_type   state_next;
   ext_bus_pkg::mem_req_type req_q_reg;
   logic [7:0]               ctrl_reg;
   logic [1:0]               stall_reg;
   logic                     loaded_reg;
   logic                     wide_reg;
   logic [1:0]               mode_reg;
   logic                     wait_en_reg;
   logic [1:0]               waits;
   logic                     bus_on;
   logic                     owned;
   logic                     strobing;
   logic                     in_cycle;
   logic [19:0]              amask;
   logic [19:0]              dmask;
   logic [15:0]              bus_wdata;
   logic [19:0]              line_dout_next;
   logic [19:0]              line_oe_n_next;
   logic [7:0]               ctl_next;
   logic                     release_bit;
   logic [1:0]               wmode;

   assign release_bit = ctrl_reg[`RELEASE_BIT];
   assign wmode       = ctrl_reg[`WMODE_HI:`WMODE_LO];
   // field 11 -> 0 waits, 00 -> 3 waits
   assign waits       = ~ctrl_reg[`STALL_HI:`STALL_LO];
   assign bus_on      = loaded_reg && (mode_reg != `MODE_OFF);
   assign in_cycle    = state_reg != ext_bus_pkg::ST_IDLE;
   // bus owns pins always when not released, else only while cycling
   assign owned       = bus_on && (!release_bit || in_cycle);
   assign strobing    = (state_reg == ext_bus_pkg::ST_DATA) ||
                        (state_reg == ext_bus_pkg::ST_STALL);
   assign amask       = line_mask(mode_reg);
   // data lines limited by width; 12-bit addressing loses data bits 15:12
   assign dmask       = (wide_reg ? `MASK_A16 : `MASK_D8) & amask;
   // byte modes copy the latch byte onto both halves
   assign bus_wdata   = (wide_reg && wmode[1]) ? req_q_reg.wdata :
                        {req_q_reg.wdata[7:0], req_q_reg.wdata[7:0]};

   // width straps caught once after reset, never writable
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         loaded_reg  <= 1'b0;
         wide_reg    <= 1'b1;
         mode_reg    <= `MODE_OFF;
         wait_en_reg <= 1'b1;
      end else if (!loaded_reg) begin
         loaded_reg  <= 1'b1;
         wide_reg    <= data_width_cfg;
         mode_reg    <= memory_mode_width_cfg;
         wait_en_reg <= wait_enable_cfg;
      end
   end

   // control register and its shared-address neighbour
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg          <= `CTRL_RESET;
         timer2_period_reg <= 8'hff;
      end else if (reg_wr && reg_addr == `CTRL_ADDR) begin
         if (!shared_addr_select)
            timer2_period_reg <= reg_wdata;
         else if (bus_on)
            ctrl_reg <= reg_wdata & `CTRL_MASK;
      end
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `CTRL_ADDR: reg_rdata <= shared_addr_select ? ctrl_reg : timer2_period_reg;
            `STAT_ADDR: reg_rdata <= {loaded_reg, wide_reg, mode_reg, wait_en_reg,
                                      owned, in_cycle, sleep_mode};
            default:    reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // sleep blocks new cycles so CE can stay high
   assign req_ready = (state_reg == ext_bus_pkg::ST_IDLE) && bus_on && !sleep_mode;

   // bus cycle sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ext_bus_pkg::ST_IDLE: begin
            if (req_valid && req_ready)
               state_next = ext_bus_pkg::ST_ADDR;
         end
         ext_bus_pkg::ST_ADDR:
            state_next = ext_bus_pkg::ST_DATA;
         ext_bus_pkg::ST_DATA: begin
            if (req_q_reg.table_op && wait_en_reg && waits != 2'h0)
               state_next = ext_bus_pkg::ST_STALL;
            else
               state_next = ext_bus_pkg::ST_DONE;
         end
         ext_bus_pkg::ST_STALL: begin
            if (stall_reg == 2'h1)
               state_next = ext_bus_pkg::ST_DONE;
         end
         ext_bus_pkg::ST_DONE:
            state_next = ext_bus_pkg::ST_IDLE;
         default:
            state_next = ext_bus_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         state_reg <= ext_bus_pkg::ST_IDLE;
      else
         state_reg <= state_next;
   end

   // request capture and wait countdown
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         req_q_reg <= '0;
         stall_reg <= 2'h0;
      end else begin
         if (req_valid && req_ready)
            req_q_reg <= req;
         if (state_reg == ext_bus_pkg::ST_DATA)
            stall_reg <= waits;
         else if (state_reg == ext_bus_pkg::ST_STALL)
            stall_reg <= stall_reg - 2'h1;
      end
   end

   // pins lag state by one cycle, so the read word is sampled in done
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         resp_valid <= 1'b0;
         resp_data  <= 16'h0000;
      end else begin
         resp_valid <= state_reg == ext_bus_pkg::ST_DONE;
         if (state_reg == ext_bus_pkg::ST_DONE && !req_q_reg.write)
            resp_data <= line_in[15:0] & dmask[15:0];
      end
   end

   // per-line drive: address phase, data phase, float, or port I/O
   genvar gi;
   generate
      for (gi = 0; gi < `LINES; gi = gi + 1) begin : g_line
         logic data_ln;
         assign data_ln = strobing && dmask[gi];
         assign line_dout_next[gi] = !(owned && amask[gi]) ? gpio_lines.dout[gi] :
                                     (data_ln ? bus_wdata[gi % 16] :
                                      req_q_reg.addr[gi]);
         assign line_oe_n_next[gi] = !(owned && amask[gi]) ? gpio_lines.oe_n[gi] :
                                     (state_reg == ext_bus_pkg::ST_ADDR) ? 1'b0 :
                                     data_ln ? !req_q_reg.write :
                                     strobing ? 1'b0 : 1'b1;
      end
   endgenerate

   // control levels, active low except ALE and BA0
   always_comb begin
      ctl_next           = `CTL_IDLE;
      ctl_next[`CTL_ALE] = state_reg == ext_bus_pkg::ST_ADDR;
      ctl_next[`CTL_CE]  = !(in_cycle && state_reg != ext_bus_pkg::ST_DONE) ||
                           sleep_mode;
      ctl_next[`CTL_OE]  = !(strobing && !req_q_reg.write);
      ctl_next[`CTL_BA0] = in_cycle && state_reg != ext_bus_pkg::ST_DONE &&
                           req_q_reg.hi_byte && (!wide_reg || wmode == 2'h1);
      if (strobing && req_q_reg.write) begin
         if (!wide_reg) begin
            ctl_next[`CTL_WRL] = 1'b0;
         end else if (wmode[1]) begin
            ctl_next[`CTL_WRH] = 1'b0;
            ctl_next[`CTL_UB]  = 1'b0;
            ctl_next[`CTL_LB]  = 1'b0;
         end else if (wmode[0]) begin
            ctl_next[`CTL_WRH] = 1'b0;
            ctl_next[`CTL_UB]  = !req_q_reg.hi_byte;
            ctl_next[`CTL_LB]  = req_q_reg.hi_byte;
         end else begin
            ctl_next[`CTL_WRH] = !req_q_reg.hi_byte;
            ctl_next[`CTL_WRL] = req_q_reg.hi_byte;
         end
      end else if (strobing && wide_reg) begin
         ctl_next[`CTL_UB] = 1'b0;
         ctl_next[`CTL_LB] = 1'b0;
      end
   end

   // registered pin drive; the bus overrides port I/O only on the pins it owns
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lines    <= '{dout: 20'h00000, oe_n: 20'hfffff};
         ctl_pins <= '{dout: `CTL_IDLE, oe_n: 8'hff};
      end else begin
         lines.dout    <= line_dout_next;
         lines.oe_n    <= line_oe_n_next;
         ctl_pins.dout <= owned ? ctl_next : ctl_gpio.dout;
         ctl_pins.oe_n <= owned ? 8'h00 : ctl_gpio.oe_n;
      end
   end

   // assertions
   property p_rsv_zero;
      @(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == `CTRL_ADDR && shared_addr_select |=>
         (reg_rdata & ~`CTRL_MASK) == 8'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

   property p_off_ignores;
      @(posedge core_clk) disable iff (!nrst)
      !bus_on |=> $stable(ctrl_reg);
   endproperty
   a_off_ignores: assert property (p_off_ignores) else $error("write taken, bus off");

   property p_own;
      @(posedge core_clk) disable iff (!nrst)
      bus_on && !release_bit |=> ctl_pins.oe_n == 8'h00;
   endproperty
   a_own: assert property (p_own) else $error("bus lost its pins");

   property p_released;
      @(posedge core_clk) disable iff (!nrst)
      bus_on && release_bit && !in_cycle |=> ctl_pins.dout == $past(ctl_gpio.dout);
   endproperty
   a_released: assert property (p_released) else $error("released pins not I/O");

   property p_wait3;
      @(posedge core_clk) disable iff (!nrst)
      state_reg == ext_bus_pkg::ST_DATA && req_q_reg.table_op && wait_en_reg &&
      ctrl_reg[`STALL_HI:`STALL_LO] == 2'h0 |=>
         state_reg == ext_bus_pkg::ST_STALL [*3] ##1 state_reg == ext_bus_pkg::ST_DONE;
   endproperty
   a_wait3: assert property (p_wait3) else $error("wrong wait count");

   property p_nowait;
      @(posedge core_clk) disable iff (!nrst)
      state_reg == ext_bus_pkg::ST_DATA && !wait_en_reg |=>
         state_reg == ext_bus_pkg::ST_DONE;
   endproperty
   a_nowait: assert property (p_nowait) else $error("wait without enable");

   property p_word_wr;
      @(posedge core_clk) disable iff (!nrst)
      state_reg == ext_bus_pkg::ST_DATA && req_q_reg.write && wide_reg && wmode[1] &&
      mode_reg != `MODE_A12 |=> !ctl_pins.dout[`CTL_WRH] && ctl_pins.dout[`CTL_WRL] &&
         lines.dout[15:0] == $past(req_q_reg.wdata);
   endproperty
   a_word_wr: assert property (p_word_wr) else $error("word write wrong");

   property p_byte_wr;
      @(posedge core_clk) disable iff (!nrst)
      state_reg == ext_bus_pkg::ST_DATA && req_q_reg.write && wide_reg &&
      wmode == 2'h0 |=> ctl_pins.dout[`CTL_WRH] != ctl_pins.dout[`CTL_WRL];
   endproperty
   a_byte_wr: assert property (p_byte_wr) else $error("byte write strobes wrong");

   property p_narrow_wr;
      @(posedge core_clk) disable iff (!nrst)
      state_reg == ext_bus_pkg::ST_DATA && req_q_reg.write && !wide_reg |=>
         ctl_pins.dout[`CTL_WRH] && !ctl_pins.dout[`CTL_WRL];
   endproperty
   a_narrow_wr: assert property (p_narrow_wr) else $error("8-bit write strobes");

   property p_upper_free;
      @(posedge core_clk) disable iff (!nrst)
      loaded_reg && mode_reg == `MODE_A16 |=>
         lines.dout[19:16] == $past(gpio_lines.dout[19:16]);
   endproperty
   a_upper_free: assert property (p_upper_free) else $error("upper lines taken");

   property p_idle_lv;
      @(posedge core_clk) disable iff (!nrst)
      bus_on && !release_bit && !in_cycle && !sleep_mode |=>
         ctl_pins.dout == `CTL_IDLE && (lines.oe_n & amask) == amask;
   endproperty
   a_idle_lv: assert property (p_idle_lv) else $error("idle levels wrong");

   property p_ale_oe;
      @(posedge core_clk) disable iff (!nrst)
      state_reg == ext_bus_pkg::ST_ADDR && !req_q_reg.write |=>
         ctl_pins.dout[`CTL_ALE] ##1 !ctl_pins.dout[`CTL_OE] && !ctl_pins.dout[`CTL_ALE];
   endproperty
   a_ale_oe: assert property (p_ale_oe) else $error("ALE then OE broken");

   property p_sleep_ce;
      @(posedge core_clk) disable iff (!nrst)
      sleep_mode && owned |=> ctl_pins.dout[`CTL_CE];
   endproperty
   a_sleep_ce: assert property (p_sleep_ce) else $error("CE low in sleep");

   c_read:  cover property (@(posedge core_clk) disable iff (!nrst)
                            resp_valid && !req_q_reg.write);
   c_write: cover property (@(posedge core_clk) disable iff (!nrst)
                            resp_valid && req_q_reg.write);
   c_stall: cover property (@(posedge core_clk) disable iff (!nrst)
                            state_reg == ext_bus_pkg::ST_STALL);
endmodule

// [sim/ext_mem_model.sv]
`timescale 1ns/10ps
`include "ext_bus_defs.svh"
// external parallel memory: latches the address, answers reads, records writes
module ext_mem_model (
   input  wire logic                 core_clk,  // bus clock
   input  ext_bus_pkg::lines_type    lines,     // device line drive
   input  ext_bus_pkg::ctl_pins_type ctl_pins,  // device control port
   output logic [19:0]               line_in,   // resolved line levels
   output logic [15:0]               addr_q,    // latched address
   output logic                      ce_at_ale, // chip enable seen at latch
   output logic [15:0]               wr_data,   // lines at write strobe
   output logic [7:0]                wr_ctl     // control at write strobe
);
   logic [19:0] last;
   logic        rd_on;
   logic        wr_on;
   // only driven control pins count, floating port i/o levels are not bus strobes
   assign rd_on = !ctl_pins.oe_n[`CTL_OE] && !ctl_pins.dout[`CTL_OE];
   assign wr_on = (!ctl_pins.oe_n[`CTL_WRL] && !ctl_pins.dout[`CTL_WRL]) ||
                  (!ctl_pins.oe_n[`CTL_WRH] && !ctl_pins.dout[`CTL_WRH]);
   // released lines flip every cycle so stale data never passes as a read
   always_comb begin
      for (int i = 0; i < 20; i++) begin
         if (!lines.oe_n[i])
            line_in[i] = lines.dout[i];
         else if (rd_on && i < 16)
            line_in[i] = addr_q[i] ^ i[0];
         else
            line_in[i] = ~last[i];
      end
   end
   // latch address on the strobe, capture data while a write strobe is low
   always_ff @(posedge core_clk) begin
      last <= line_in;
      if (!ctl_pins.oe_n[`CTL_ALE] && ctl_pins.dout[`CTL_ALE]) begin
         addr_q <= line_in[15:0];
         ce_at_ale <= ctl_pins.dout[`CTL_CE];
      end
      if (wr_on) begin
         wr_data <= line_in[15:0];
         wr_ctl <= ctl_pins.dout;
      end
   end
endmodule

// [sim/external_memory_bus_control_bench.sv]
`timescale 1ns/10ps
`include "ext_bus_defs.svh"
module external_memory_bus_control_bench;
   logic                      core_clk = 1'b0;
   logic                      nrst = 1'b0;
   logic [3:0]                reg_addr = 4'h0;
   logic [7:0]                reg_wdata = 8'h00;
   logic                      reg_wr = 1'b0;
   logic                      reg_rd = 1'b0;
   logic                      sel = 1'b1;
   logic [1:0]                mode = `MODE_A16;
   logic                      slp = 1'b0;
   logic                      wide = 1'b1;
   logic                      wen = 1'b1;
   logic                      req_valid = 1'b0;
   ext_bus_pkg::mem_req_type  req = '0;
   ext_bus_pkg::lines_type    gpio_lines = {20'h9c3a1, 20'h0f0f0};
   ext_bus_pkg::ctl_pins_type ctl_gpio = {8'h5a, 8'h0f};
   logic [7:0]                reg_rdata, period;
   logic                      req_ready, resp_valid;
   logic [15:0]               resp_data, addr_q, wr_data;
   logic [19:0]               line_in;
   ext_bus_pkg::lines_type    lines;
   ext_bus_pkg::ctl_pins_type ctl_pins;
   logic                      ce_at_ale;
   logic [7:0]                wr_ctl, v;
   int                        n_fail = 0, samples_checked = 0, cycles = 0, n;

   always #20 core_clk = ~core_clk;

   // 16-bit data with 16-bit addressing keeps address width >= data width
   external_memory_bus_control uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .shared_addr_select(sel), .timer2_period_reg(period), .data_width_cfg(wide),
      .memory_mode_width_cfg(mode), .wait_enable_cfg(wen), .sleep_mode(slp),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_data(resp_data), .line_in(line_in), .gpio_lines(gpio_lines), .lines(lines),
      .ctl_gpio(ctl_gpio), .ctl_pins(ctl_pins));
   ext_mem_model mem (.core_clk(core_clk), .lines(lines), .ctl_pins(ctl_pins),
      .line_in(line_in), .addr_q(addr_q), .ce_at_ale(ce_at_ale), .wr_data(wr_data),
      .wr_ctl(wr_ctl));

   task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // a hang costs one mismatch and ends the run
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         stop_test;
      end
   end

   task automatic do_reset(input logic [1:0] m, input logic w, input logic we);
      @(posedge core_clk);
      mode <= m;
      wide <= w;
      wen <= we;
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d, input logic s);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      sel <= s;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      sel <= 1'b1;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // n ends as the count of edges from taking to the done pulse
   task automatic access(input logic wr, tb, hi, input logic [19:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= '{wr, tb, hi, a, d};
      n = 0;
      @(negedge core_clk);
      while (req_ready !== 1'b1 && n < 50) begin
         n++;
         @(negedge core_clk);
      end
      @(posedge core_clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (resp_valid !== 1'b1 && n < 50);
   endtask

   task automatic t_reset;
      reg_read(`CTRL_ADDR, v);
      check("control reset", v, `CTRL_RESET);
      check("idle control", ctl_pins, {`CTL_IDLE, 8'h00});
      check("idle lines float", lines.oe_n[15:0], 16'hffff);
      check("upper lines", lines[39:36], gpio_lines[39:36]);
      $display("reset test done");
   endtask

   task automatic t_regs;
      reg_write(`CTRL_ADDR, 8'hff, 1'b1);
      reg_read(`CTRL_ADDR, v);
      check("control bits", v, 8'hb3);
      reg_write(`CTRL_ADDR, 8'h5a, 1'b0);
      reg_read(`CTRL_ADDR, v);
      check("period reg", period, 8'h5a);
      check("control kept", v, 8'hb3);
      reg_read(4'hf, v);
      check("unmapped read", v, 8'h00);
      $display("register test done");
   endtask

   task automatic t_read;
      reg_write(`CTRL_ADDR, 8'h30, 1'b1);
      access(1'b0, 1'b1, 1'b0, 20'h0a5c3, 16'h0000);
      check("read cycles wait 11", n, 3);
      check("read word", resp_data, 16'ha5c3 ^ 16'haaaa);
      check("latched addr", addr_q, 16'ha5c3);
      check("chip enable", ce_at_ale, 1'b0);
      reg_write(`CTRL_ADDR, 8'h00, 1'b1);
      access(1'b0, 1'b1, 1'b0, 20'h01234, 16'h0000);
      check("read cycles wait 00", n, 6);
      check("mux read word", resp_data, 16'h1234 ^ 16'haaaa);
      access(1'b0, 1'b0, 1'b0, 20'h04321, 16'h0000);
      check("fetch no wait", n, 3);
      $display("read test done");
   endtask

   task automatic wr_case(input logic [1:0] wm, input logic hi, input logic [3:0] mask,
                          input logic [3:0] strb, input logic [15:0] d);
      reg_write(`CTRL_ADDR, {6'h0c, wm}, 1'b1);
      access(1'b1, 1'b1, hi, 20'h00f0e, 16'hc37e);
      check("write strobes", {wr_ctl[7:6], wr_ctl[3:2]} & mask, strb);
      check("write data", wr_data, d);
   endtask

   task automatic t_write;
      wr_case(2'h3, 1'b0, 4'hf, 4'h1, 16'hc37e);
      wr_case(2'h1, 1'b1, 4'hf, 4'h5, 16'h7e7e);
      wr_case(2'h0, 1'b0, 4'h3, 4'h2, 16'h7e7e);
      $display("write test done");
   endtask

   task automatic t_release;
      reg_write(`CTRL_ADDR, 8'hb0, 1'b1);
      repeat (2) @(posedge core_clk);
      check("released control", ctl_pins, ctl_gpio);
      check("released lines", lines[35:20], gpio_lines[35:20]);
      access(1'b0, 1'b1, 1'b0, 20'h0beef, 16'h0000);
      check("takeover read", resp_data, 16'hbeef ^ 16'haaaa);
      $display("release test done");
   endtask

   task automatic t_sleep;
      // bus must own the control port, else CE is plain port i/o
      reg_write(`CTRL_ADDR, 8'h30, 1'b1);
      @(posedge core_clk);
      slp <= 1'b1;
      @(negedge core_clk);
      @(negedge core_clk);
      check("sleep ready", req_ready, 1'b0);
      check("sleep chip enable", ctl_pins.dout[`CTL_CE], 1'b1);
      @(posedge core_clk);
      slp <= 1'b0;
      $display("sleep test done");
   endtask

   task automatic t_off;
      do_reset(`MODE_OFF, 1'b1, 1'b1);
      reg_write(`CTRL_ADDR, 8'h33, 1'b1);
      reg_read(`CTRL_ADDR, v);
      check("bus off control", v, 8'h00);
      check("bus off ready", req_ready, 1'b0);
      $display("bus off test done");
   endtask

   // 8-bit data strap with waits strapped off; lines 15:8 keep the address
   task automatic t_narrow;
      do_reset(`MODE_A16, 1'b0, 1'b0);
      reg_write(`CTRL_ADDR, 8'h03, 1'b1);
      access(1'b1, 1'b1, 1'b1, 20'h00f0e, 16'hc37e);
      check("narrow strobes", wr_ctl[3:2], 2'h2);
      check("narrow data", wr_data, 16'h0f7e);
      access(1'b0, 1'b1, 1'b0, 20'h0a5c3, 16'h0000);
      check("strap no wait", n, 3);
      check("narrow read", resp_data, 16'h00c3 ^ 16'h00aa);
      $display("narrow test done");
   endtask

   initial begin
      do_reset(`MODE_A16, 1'b1, 1'b1);
      t_reset;
      t_regs;
      t_read;
      t_write;
      t_release;
      t_sleep;
      t_narrow;
      t_off;
      stop_test;
   end
endmodule
